// ===== rtl/echo_processor_io_interface.sv
// Behaviour
// - Send-side output is a 2.048 Mb/s serial stream of 32 channels.
// - A host access happens only while strobe and chip select are both low.
// - The direction input drives data out on reads and samples it on writes.
// - Completion is shown by pulling the open-drain acknowledge low, never high.
// - Serial outputs drive only when the enable pin and control bit 6 are both high.
// - The frame pulse format is detected automatically between two formats.
// - All four streams shift on the externally supplied 4.096 MHz clock.
// - Master clock needs no relation to the frame pulse.
// - Interrupt output is pulled low when any channel raises an event.
// - Interrupt output is released only after every FIFO entry has been read.
// - Host activity is ignored while chip select is high.
// - Both input streams are received at 2.048 Mb/s with 32 channels.
// - Receive-side output is a 2.048 Mb/s serial stream of 32 channels.
`default_nettype none
module echo_processor_io_interface #(
   parameter int IRQ_DEPTH = evp_io_pkg::IRQ_DEPTH
) (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic        freq_select,
   input  wire logic        chip_select_n,
   input  wire logic        host_strobe_n,
   input  wire logic        host_read,
   input  wire logic [12:0] hostAddr,
   input  wire logic [7:0]  hostDataIn,
   output logic      [7:0]  hostDataOut,
   output logic             hostDataOe,
   output logic             transfer_ack_n_out,
   output logic             transfer_ack_n_oe,
   output logic             irq_n_out,
   output logic             irq_n_oe,
   input  wire logic [31:0] channelEvent,
   input  wire logic        serial_shift_clock,
   input  wire logic        frame_pulse_in,
   input  wire logic        serial_drive_enable,
   input  wire logic        rinData,
   input  wire logic        sinData,
   output logic             routData,
   output logic             routOe,
   output logic             soutData,
   output logic             soutOe,
   output logic [7:0]       lastRxByte,
   output logic [7:0]       lastSxByte,
   output logic             masterIsSlow
);
   logic rstS1, rstS2, rst_n;
   logic linkS1, linkRst_n;
   logic csS1, csS2, dsS1, dsS2, rwS1, rwS2, fsS1, fsS2, odeS1, odeS2;
   logic access, prevAccess, accessStart;
   logic [7:0] mainCtrl, next_mainCtrl;
   logic ackOn, next_ackOn;
   logic [7:0] readData, next_readData;
   logic [4:0] fifoMem [IRQ_DEPTH];
   logic [evp_io_pkg::IRQ_PTR_W:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
   logic fifoEmpty, fifoFull, popNow;
   logic [4:0] evtChan;
   logic evtAny;
   logic slS1, slS2, slS3, frS1, frS2, frS3;
   logic [7:0] rxCap, sxCap;
   logic driveReq, driveSync1, driveSync2;

   tdm_link_if lnk ();

   // Reset release on each clock
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstS1 <= 1'b0;
         rstS2 <= 1'b0;
      end else begin
         rstS1 <= 1'b1;
         rstS2 <= rstS1;
      end
   end
   assign rst_n = rstS2;

   always_ff @(posedge serial_shift_clock or negedge arst_n) begin
      if (!arst_n) begin
         linkS1 <= 1'b0;
         linkRst_n <= 1'b0;
      end else begin
         linkS1 <= 1'b1;
         linkRst_n <= linkS1;
      end
   end

   tdm_serial_port u_port (
      .serial_shift_clock (serial_shift_clock),
      .linkRst_n          (linkRst_n),
      .frame_pulse_in     (frame_pulse_in),
      .rinData            (rinData),
      .sinData            (sinData),
      .routData           (routData),
      .soutData           (soutData),
      .lnk                (lnk.link)
   );

   // Host pins are asynchronous to core_clk
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {csS1, csS2, dsS1, dsS2} <= 4'hF;
         {rwS1, rwS2, fsS1, fsS2, odeS1, odeS2} <= 6'h00;
         prevAccess <= 1'b0;
         driveReq <= 1'b0;
      end else begin
         csS1 <= chip_select_n;
         csS2 <= csS1;
         dsS1 <= host_strobe_n;
         dsS2 <= dsS1;
         rwS1 <= host_read;
         rwS2 <= rwS1;
         fsS1 <= freq_select;
         fsS2 <= fsS1;
         odeS1 <= serial_drive_enable;
         odeS2 <= odeS1;
         prevAccess <= access;
         // Registered so the link synchroniser never sees a gate glitch
         driveReq <= odeS2 && mainCtrl[evp_io_pkg::CTRL_DRIVE_BIT];
      end
   end

   assign access = !csS2 && !dsS2;
   assign accessStart = access && !prevAccess;
   assign fifoEmpty = (wrPtr == rdPtr);
   assign fifoFull = (wrPtr[evp_io_pkg::IRQ_PTR_W] != rdPtr[evp_io_pkg::IRQ_PTR_W])
                  && (wrPtr[evp_io_pkg::IRQ_PTR_W-1:0] == rdPtr[evp_io_pkg::IRQ_PTR_W-1:0]);
   assign popNow = accessStart && rwS2 && hostAddr == evp_io_pkg::ADDR_IRQ_FIFO && !fifoEmpty;

   // Lowest-numbered raised channel is queued; others wait a cycle (events must be held)
   always_comb begin
      evtAny = 1'b0;
      evtChan = '0;
      for (int i = evp_io_pkg::CHANNELS - 1; i >= 0; i--) begin
         if (channelEvent[i]) begin
            evtAny = 1'b1;
            evtChan = 5'(i);
         end
      end
   end

   always_comb begin
      next_mainCtrl = mainCtrl;
      next_readData = readData;
      next_ackOn = access;
      next_wrPtr = wrPtr;
      next_rdPtr = rdPtr;
      if (accessStart) begin
         if (rwS2) begin
            if (hostAddr == evp_io_pkg::ADDR_MAIN_CTRL) begin
               next_readData = mainCtrl;
            end else if (hostAddr == evp_io_pkg::ADDR_IRQ_FIFO) begin
               next_readData = fifoEmpty ? evp_io_pkg::IRQ_EMPTY_CODE
                                         : {3'h0, fifoMem[rdPtr[evp_io_pkg::IRQ_PTR_W-1:0]]};
            end else begin
               next_readData = 8'h00;
            end
         end else if (hostAddr == evp_io_pkg::ADDR_MAIN_CTRL) begin
            next_mainCtrl = hostDataIn;
         end
      end
      if (popNow) begin
         next_rdPtr = rdPtr + 1'b1;
      end
      if (evtAny && !fifoFull) begin
         next_wrPtr = wrPtr + 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mainCtrl <= evp_io_pkg::CTRL_RESET;
         readData <= 8'h00;
         ackOn <= 1'b0;
         wrPtr <= '0;
         rdPtr <= '0;
      end else begin
         mainCtrl <= next_mainCtrl;
         readData <= next_readData;
         ackOn <= next_ackOn;
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
      end
   end

   always_ff @(posedge core_clk) begin
      if (evtAny && !fifoFull) begin
         fifoMem[wrPtr[evp_io_pkg::IRQ_PTR_W-1:0]] <= evtChan;
      end
   end

   assign hostDataOut = readData;
   assign hostDataOe = access && rwS2 && ackOn;
   assign transfer_ack_n_out = 1'b0;
   assign transfer_ack_n_oe = ackOn && access;
   assign irq_n_out = 1'b0;
   assign irq_n_oe = !fifoEmpty;
   assign masterIsSlow = fsS2;

   // Slot words cross by toggle; data stable long before toggle settles
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {slS1, slS2, slS3, frS1, frS2, frS3} <= 6'h00;
         rxCap <= 8'h00;
         sxCap <= 8'h00;
      end else begin
         slS1 <= lnk.slotDone;
         slS2 <= slS1;
         slS3 <= slS2;
         frS1 <= lnk.frameSeen;
         frS2 <= frS1;
         frS3 <= frS2;
         if (slS2 != slS3) begin
            rxCap <= lnk.rxByte;
            sxCap <= lnk.sxByte;
         end
      end
   end
   assign lastRxByte = rxCap;
   assign lastSxByte = sxCap;

   // Drive enable moves to the shift-clock domain for the pins
   always_ff @(posedge serial_shift_clock or negedge linkRst_n) begin
      if (!linkRst_n) begin
         driveSync1 <= 1'b0;
         driveSync2 <= 1'b0;
      end else begin
         driveSync1 <= driveReq;
         driveSync2 <= driveSync1;
      end
   end
   assign routOe = driveSync2;
   assign soutOe = driveSync2;

   sequence accessHeld;
      accessStart ##1 access;
   endsequence

   chk_ack_release: assert property (@(posedge core_clk) disable iff (!rst_n)
      !access |-> !transfer_ack_n_oe) else $error("ack held after strobe");
   chk_ack_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
      accessHeld |-> transfer_ack_n_oe) else $error("ack missing");
   chk_ack_low: assert property (@(posedge core_clk) disable iff (!rst_n)
      transfer_ack_n_out == 1'b0) else $error("ack driven high");
   chk_irq_event: assert property (@(posedge core_clk) disable iff (!rst_n)
      (evtAny && !fifoFull) |=> irq_n_oe) else $error("irq not raised");
   chk_irq_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      (irq_n_oe && !popNow && !(evtAny && !fifoFull)) |=> (irq_n_oe == !fifoEmpty) && irq_n_oe)
      else $error("irq dropped early");
   chk_cs_ignore: assert property (@(posedge core_clk) disable iff (!rst_n)
      csS2 |=> $stable(mainCtrl)) else $error("write while deselected");
   chk_write_take: assert property (@(posedge core_clk) disable iff (!rst_n)
      (accessStart && !rwS2 && hostAddr == evp_io_pkg::ADDR_MAIN_CTRL) |=> mainCtrl == $past(hostDataIn))
      else $error("write lost");
   chk_read_dir: assert property (@(posedge core_clk) disable iff (!rst_n)
      hostDataOe |-> (rwS2 && access)) else $error("bus driven on write");
   chk_drive_gate: assert property (@(posedge serial_shift_clock) disable iff (!linkRst_n)
      routOe |-> $past(driveSync1)) else $error("drive gate wrong");
endmodule // echo_processor_io_interface
`default_nettype wire

// ===== rtl/evp_io_pkg.sv
`default_nettype none
package evp_io_pkg;
   localparam int CHANNELS        = 32;
   localparam int SLOT_BITS       = 8;
   localparam int CHAN_W          = 5;
   localparam int BIT_W           = 3;
   localparam int ADDR_W          = 13;
   localparam int DATA_W          = 8;
   localparam int IRQ_DEPTH       = 16;
   localparam int IRQ_PTR_W       = 4;
   localparam int CTRL_DRIVE_BIT  = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Two shift clocks per data bit: 4.096 MHz clock, 2.048 Mb/s data
   localparam int CLKS_PER_BIT    = 2;
   // Register addresses inside the host window
   localparam logic [12:0] ADDR_MAIN_CTRL = 13'h0000;
   localparam logic [12:0] ADDR_IRQ_FIFO  = 13'h0001;
   localparam logic [7:0]  IRQ_EMPTY_CODE = 8'hFF;
endpackage
`default_nettype wire

// ===== rtl/tdm_link_if.sv
`default_nettype none
interface tdm_link_if;
   logic        frameSeen;
   logic        slotDone;
   logic [4:0]  slotChan;
   logic [7:0]  rxByte;
   logic [7:0]  sxByte;
   modport link (output frameSeen, output slotDone, output slotChan, output rxByte, output sxByte);
   modport core (input frameSeen, input slotDone, input slotChan, input rxByte, input sxByte);
endinterface
`default_nettype wire

// ===== rtl/tdm_serial_port.sv
`default_nettype none
module tdm_serial_port (
   input  wire logic  serial_shift_clock,
   input  wire logic  linkRst_n,
   input  wire logic  frame_pulse_in,
   input  wire logic  rinData,
   input  wire logic  sinData,
   output logic       routData,
   output logic       soutData,
   tdm_link_if.link   lnk
);
   logic                            phase, next_phase;
   logic [evp_io_pkg::BIT_W-1:0]    bitCnt, next_bitCnt;
   logic [evp_io_pkg::CHAN_W-1:0]   chan, next_chan;
   logic [7:0]                      rxSh, next_rxSh, sxSh, next_sxSh;
   logic                            fpPrev, fpPrev2, gciFmt, next_gciFmt;
   logic                            frameTgl, next_frameTgl, slotTgl, next_slotTgl;
   logic [7:0]                      rxHold, next_rxHold, sxHold, next_sxHold;
   logic [evp_io_pkg::CHAN_W-1:0]   chanHold, next_chanHold;
   logic                            fpStart;

   // Backplane pulse is low-active, GCI high-active; level outside the pulse reveals the format
   assign fpStart = gciFmt ? (frame_pulse_in & ~fpPrev) : (~frame_pulse_in & fpPrev);

   always_comb begin
      next_phase = ~phase;
      next_bitCnt = bitCnt;
      next_chan = chan;
      next_rxSh = rxSh;
      next_sxSh = sxSh;
      next_frameTgl = frameTgl;
      next_slotTgl = slotTgl;
      next_rxHold = rxHold;
      next_sxHold = sxHold;
      next_chanHold = chanHold;
      next_gciFmt = gciFmt;
      // Pulse spans at most two shift clocks, so three equal samples give the resting level
      if (frame_pulse_in == fpPrev && fpPrev == fpPrev2) begin
         next_gciFmt = ~frame_pulse_in;
      end
      if (fpStart) begin
         // Bit 0 stands for this edge and the next; the next one samples it
         next_phase = 1'b1;
         next_bitCnt = '0;
         next_chan = '0;
         next_frameTgl = ~frameTgl;
      end else if (phase) begin
         // Sample mid-bit on second shift clock of each bit
         next_rxSh = {rxSh[6:0], rinData};
         next_sxSh = {sxSh[6:0], sinData};
         next_bitCnt = bitCnt + 1'b1;
         if (bitCnt == 3'(evp_io_pkg::SLOT_BITS - 1)) begin
            next_rxHold = {rxSh[6:0], rinData};
            next_sxHold = {sxSh[6:0], sinData};
            next_chanHold = chan;
            next_slotTgl = ~slotTgl;
            next_chan = chan + 1'b1;
         end
      end
   end

   always_ff @(posedge serial_shift_clock or negedge linkRst_n) begin
      if (!linkRst_n) begin
         phase <= 1'b0;
         bitCnt <= '0;
         chan <= '0;
         rxSh <= 8'h00;
         sxSh <= 8'h00;
         fpPrev <= 1'b1;
         fpPrev2 <= 1'b1;
         gciFmt <= 1'b0;
         frameTgl <= 1'b0;
         slotTgl <= 1'b0;
         rxHold <= 8'h00;
         sxHold <= 8'h00;
         chanHold <= '0;
      end else begin
         phase <= next_phase;
         bitCnt <= next_bitCnt;
         chan <= next_chan;
         rxSh <= next_rxSh;
         sxSh <= next_sxSh;
         fpPrev <= frame_pulse_in;
         fpPrev2 <= fpPrev;
         gciFmt <= next_gciFmt;
         frameTgl <= next_frameTgl;
         slotTgl <= next_slotTgl;
         rxHold <= next_rxHold;
         sxHold <= next_sxHold;
         chanHold <= next_chanHold;
      end
   end

   // Echo processing lies outside this block: each input passes to its own output (Rin to Rout, Sin to Sout), one shift clock later
   always_ff @(posedge serial_shift_clock or negedge linkRst_n) begin
      if (!linkRst_n) begin
         routData <= 1'b1;
         soutData <= 1'b1;
      end else begin
         routData <= rinData;
         soutData <= sinData;
      end
   end

   assign lnk.frameSeen = frameTgl;
   assign lnk.slotDone  = slotTgl;
   assign lnk.slotChan  = chanHold;
   assign lnk.rxByte    = rxHold;
   assign lnk.sxByte    = sxHold;

   chk_chan_wrap: assert property (@(posedge serial_shift_clock) disable iff (!linkRst_n)
      (phase && !fpStart && bitCnt == 3'(evp_io_pkg::SLOT_BITS - 1)) |=> (chan == $past(chan) + 5'h01))
      else $error("channel not advanced");
   chk_frame_restart: assert property (@(posedge serial_shift_clock) disable iff (!linkRst_n)
      fpStart |=> (chan == '0 && bitCnt == '0 && phase)) else $error("frame restart missed");
   chk_bit_pace: assert property (@(posedge serial_shift_clock) disable iff (!linkRst_n)
      (!phase && !fpStart) |=> $stable(bitCnt)) else $error("bit pace wrong");
endmodule // tdm_serial_port
`default_nettype wire

// ===== sim/tdm_backplane_model.sv
`default_nettype none
module tdm_backplane_model (
   output logic serial_shift_clock,
   output logic frame_pulse_in,
   output logic rinData,
   output logic sinData
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam real HALF = 62.5;

   initial begin
      serial_shift_clock = 1'b1;
      frame_pulse_in = 1'b1;
      rinData = 1'b1;
      sinData = 1'b1;
      #37; // No phase tie to the core clock
      // Clocks only around reset, then still until a frame
      repeat (16) #HALF serial_shift_clock = ~serial_shift_clock;
   end

   // Idle edges lead the pulse so its resting level is seen first
   task automatic sendFrame(input logic gci, input logic [7:0] rb, input logic [7:0] sb);
      int i;
      frame_pulse_in = ~gci;
      for (i = -8; i < 520; i++) begin
         serial_shift_clock = 1'b0;
         if (i == 0)
            frame_pulse_in = gci;
         if (i == 2)
            frame_pulse_in = ~gci;
         if (i >= 0 && i < 512 && i % 2 == 0) begin
            rinData = rb[7 - (i / 2) % 8];
            sinData = sb[7 - (i / 2) % 8];
         end
         #HALF serial_shift_clock = 1'b1;
         #HALF;
      end
      // Released lines must not keep a stale level
      rinData = ~rinData;
      sinData = ~sinData;
   endtask
endmodule // tdm_backplane_model
`default_nettype wire

// ===== sim/test_echo_processor_io_interface.sv
`default_nettype none
module test_echo_processor_io_interface;
   timeunit 1ns;
   timeprecision 100ps;
   logic        core_clk, arst_n, freq_select, chip_select_n, host_strobe_n, host_read;
   logic [12:0] hostAddr;
   logic [7:0]  hostDataIn, hostDataOut, lastRxByte, lastSxByte;
   logic        hostDataOe, transfer_ack_n_out, transfer_ack_n_oe, irq_n_out, irq_n_oe;
   logic [31:0] channelEvent;
   logic        serial_shift_clock, frame_pulse_in, serial_drive_enable, rinData, sinData;
   logic        routData, routOe, soutData, soutOe, masterIsSlow;
   logic        ackLine, irqLine, rinSeen, rinSeen2, sinSeen, sinSeen2;
   int          n_errors = 0;
   int          compares = 0;

   // Pull-ups on the open-drain lines
   assign ackLine = transfer_ack_n_oe ? transfer_ack_n_out : 1'b1;
   assign irqLine = irq_n_oe ? irq_n_out : 1'b1;

   echo_processor_io_interface #(.IRQ_DEPTH(evp_io_pkg::IRQ_DEPTH)) dut_u (
      .core_clk, .arst_n, .freq_select, .chip_select_n, .host_strobe_n, .host_read, .hostAddr,
      .hostDataIn, .hostDataOut, .hostDataOe, .transfer_ack_n_out, .transfer_ack_n_oe, .irq_n_out,
      .irq_n_oe, .channelEvent, .serial_shift_clock, .frame_pulse_in, .serial_drive_enable, .rinData,
      .sinData, .routData, .routOe, .soutData, .soutOe, .lastRxByte, .lastSxByte, .masterIsSlow
   );
   tdm_backplane_model backplane (.serial_shift_clock, .frame_pulse_in, .rinData, .sinData);

   always #10 core_clk = ~core_clk;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results;
      $display("Errors %0d, compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic access(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] q);
      int n;
      @(posedge core_clk);
      chip_select_n <= 1'b0;
      host_strobe_n <= 1'b0;
      host_read     <= rd;
      hostAddr      <= a;
      hostDataIn    <= wd;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (ackLine !== 1'b0 && n < 20);
      q = hostDataOut;
      check(8'(n < 20), 8'h01);
      check(8'(hostDataOe), 8'(rd));
      chip_select_n <= 1'b1;
      host_strobe_n <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (ackLine !== 1'b1 && n < 20);
      check(8'(n < 20), 8'h01);
      @(posedge core_clk);
   endtask

   task automatic writeReg(input logic [12:0] a, input logic [7:0] d);
      logic [7:0] q;
      access(1'b0, a, d, q);
   endtask

   task automatic readExpect(input logic [12:0] a, input logic [7:0] exp);
      logic [7:0] q;
      access(1'b1, a, 8'hC3, q);
      check(q, exp);
   endtask

   // Half an access must never be acknowledged
   task automatic halfAccess(input logic csN, input logic strobeN);
      @(posedge core_clk);
      host_read     <= 1'b0;
      hostAddr      <= evp_io_pkg::ADDR_MAIN_CTRL;
      hostDataIn    <= 8'h00;
      chip_select_n <= csN;
      host_strobe_n <= strobeN;
      repeat (10) begin
         @(posedge core_clk);
         check(8'(ackLine), 8'h01);
      end
      chip_select_n <= 1'b1;
      host_strobe_n <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask

   task automatic clockSelect;
      freq_select <= 1'b1;
      repeat (5) @(posedge core_clk);
      check(8'(masterIsSlow), 8'h01);
      freq_select <= 1'b0;
      repeat (5) @(posedge core_clk);
      check(8'(masterIsSlow), 8'h00);
   endtask

   task automatic hostRegs;
      writeReg(evp_io_pkg::ADDR_MAIN_CTRL, 8'h40);
      readExpect(evp_io_pkg::ADDR_MAIN_CTRL, 8'h40);
      writeReg(13'h1FFF, 8'h77);
      readExpect(13'h1FFF, 8'h00);
      halfAccess(1'b1, 1'b0);
      halfAccess(1'b0, 1'b1);
      readExpect(evp_io_pkg::ADDR_MAIN_CTRL, 8'h40);
   endtask

   // Fills the event queue to its depth, then drains it
   task automatic irqFlow;
      int ch;
      check(8'(irqLine), 8'h01);
      for (ch = 0; ch < evp_io_pkg::IRQ_DEPTH; ch++) begin
         @(posedge core_clk);
         channelEvent <= 32'h1 << (2 * ch + 1);
      end
      @(posedge core_clk);
      channelEvent <= 32'h0;
      repeat (4) @(posedge core_clk);
      for (ch = 0; ch < evp_io_pkg::IRQ_DEPTH; ch++) begin
         check(8'(irqLine), 8'h00);
         readExpect(evp_io_pkg::ADDR_IRQ_FIFO, 8'(2 * ch + 1));
      end
      repeat (4) @(posedge core_clk);
      check(8'(irqLine), 8'h01);
      readExpect(evp_io_pkg::ADDR_IRQ_FIFO, evp_io_pkg::IRQ_EMPTY_CODE);
   endtask

   task automatic serialCase(input logic pin, input logic ctl, input logic gci, input logic [7:0] rb,
                             input logic [7:0] sb);
      writeReg(evp_io_pkg::ADDR_MAIN_CTRL, 8'(ctl) << evp_io_pkg::CTRL_DRIVE_BIT);
      serial_drive_enable <= pin;
      fork
         backplane.sendFrame(gci, rb, sb);
         begin
            repeat (1500) @(posedge core_clk);
            check(8'(routOe), 8'(pin & ctl));
            check(8'(soutOe), 8'(pin & ctl));
         end
      join
      repeat (10) @(posedge core_clk);
      check(lastRxByte, rb);
      check(lastSxByte, sb);
   endtask

   always @(posedge serial_shift_clock) begin
      rinSeen2 <= rinSeen;
      rinSeen  <= rinData;
      sinSeen2 <= sinSeen;
      sinSeen  <= sinData;
   end

   // Only settled runs are judged, so the output edge choice does not matter
   always @(negedge serial_shift_clock)
      if (routOe === 1'b1 && rinSeen === rinSeen2 && sinSeen === sinSeen2) begin
         check(8'(routData), 8'(rinSeen));
         check(8'(soutData), 8'(sinSeen));
      end

   initial begin
      core_clk = 1'b0;
      arst_n = 1'b0;
      freq_select = 1'b0;
      chip_select_n = 1'b1;
      host_strobe_n = 1'b1;
      host_read = 1'b0;
      hostAddr = 13'h0000;
      hostDataIn = 8'h00;
      channelEvent = 32'h0;
      serial_drive_enable = 1'b0;
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      clockSelect;
      hostRegs;
      irqFlow;
      // Bytes are not rotations of themselves, so a bit slip shows
      serialCase(1'b1, 1'b1, 1'b0, 8'hA5, 8'h3C);
      serialCase(1'b1, 1'b1, 1'b1, 8'h3C, 8'hA5);
      serialCase(1'b0, 1'b1, 1'b1, 8'h96, 8'h5A);
      serialCase(1'b1, 1'b0, 1'b0, 8'h5A, 8'h96);
      results;
   end

   initial begin
      repeat (40000) @(posedge core_clk);
      n_errors++;
      results;
   end
endmodule // test_echo_processor_io_interface
`default_nettype wire
